// File: hdl/pbsi_pkg.sv
/*
 package of the power button and standby input block: timing, debounce,
 hold thresholds and latch bit positions.
 assumes a 200 MHz core clock.
*/
package pbsi_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int MS_TICK_MS = 1;
	localparam int MS_TICK_CYCLES = MS_TICK_MS * CLK_FREQ_KHZ;
	localparam int DISCHARGE_US = 30;
	localparam int DISCHARGE_CYCLES = (DISCHARGE_US * CLK_FREQ_KHZ) / 1000;
	localparam int TICK_W = 18;
	localparam int DISCH_W = 13;

	// ------------------------------------------------------------
	// debounce
	// ------------------------------------------------------------
	localparam int DBNC_W = 10;
	localparam logic [DBNC_W-1:0] DBNC_SHORT_MS = 10'h020;
	localparam logic [DBNC_W-1:0] DBNC_MID_MS = 10'h07d;
	localparam logic [DBNC_W-1:0] DBNC_LONG_MS = 10'h2ee;
	localparam logic [1:0] DBNC_CODE_MID = 2'h2;
	localparam logic [1:0] DBNC_CODE_LONG = 2'h3;

	// ------------------------------------------------------------
	// hold and long press
	// ------------------------------------------------------------
	localparam int HOLD_W = 14;
	localparam int HOLD_N = 5;
	localparam logic [HOLD_N-1:0][HOLD_W-1:0] HOLD_MS = {14'h1f40, 14'h0fa0, 14'h0bb8, 14'h07d0, 14'h03e8};
	localparam logic [3:0][HOLD_W-1:0] LONG_PRESS_MS = {14'h3e80, 14'h1f40, 14'h0fa0, 14'h07d0};

	// ------------------------------------------------------------
	// latch bits
	// ------------------------------------------------------------
	localparam int LATCH_N = 7;
	localparam int LAT_PRESS = 0;
	localparam int LAT_RELEASE = 1;
	localparam int LAT_HOLD0 = 2;
	localparam logic [LATCH_N-1:0] LATCH_RESET = 7'h00;
endpackage

// File: hdl/pbsi_btn_if.sv
/*
 carrier between the button filter and the controller.
 assumes both ends on core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface pbsi_btn_if;
	logic [1:0] dbnc_sel;
	logic pin_level;
	logic pressed;
	logic press_p;
	logic release_p;
	logic hold_tick;
	logic [pbsi_pkg::HOLD_W-1:0] hold_ms;
	modport filt (input dbnc_sel, output pin_level, pressed, press_p, release_p, hold_tick, hold_ms);
	modport ctrl (output dbnc_sel, input pin_level, pressed, press_p, release_p, hold_tick, hold_ms);
endinterface
`default_nettype wire

// File: hdl/pbsi_btn_filter.sv
/*
 button pin synchroniser, debounce and hold timer.
 assumes an asynchronous pin; a press pulls it low.
*/
`timescale 1ns/1ps
`default_nettype none
module pbsi_btn_filter #(
	parameter int MS_CYCLES = pbsi_pkg::MS_TICK_CYCLES
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// pin
	input wire logic pin_i,
	// controller side
	pbsi_btn_if.filt bif
);
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic pressed;
		logic [pbsi_pkg::TICK_W-1:0] tick_cnt;
		logic [pbsi_pkg::DBNC_W-1:0] dbnc_ms;
		logic [pbsi_pkg::HOLD_W-1:0] hold_ms;
		logic press_p;
		logic release_p;
		logic hold_tick;
	} pbsi_filt_state_t;

	pbsi_filt_state_t st;
	pbsi_filt_state_t next_st;
	logic ms_tick;
	logic [pbsi_pkg::DBNC_W-1:0] dbnc_lim;

	// ------------------------------------------------------------
	// debounce and hold
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.press_p = 1'b0;
		next_st.release_p = 1'b0;
		next_st.hold_tick = 1'b0;
		next_st.sync = {st.sync[1:0], pin_i};
		if (st.sync[2] == st.sync[1]) begin
			next_st.level = st.sync[2];
		end
		ms_tick = (st.tick_cnt == pbsi_pkg::TICK_W'(MS_CYCLES - 1));
		next_st.tick_cnt = ms_tick ? '0 : st.tick_cnt + 1'b1;
		dbnc_lim = pbsi_pkg::DBNC_SHORT_MS;
		if (!st.pressed) begin
			case (bif.dbnc_sel)
				pbsi_pkg::DBNC_CODE_MID: dbnc_lim = pbsi_pkg::DBNC_MID_MS;
				pbsi_pkg::DBNC_CODE_LONG: dbnc_lim = pbsi_pkg::DBNC_LONG_MS;
				default: dbnc_lim = pbsi_pkg::DBNC_SHORT_MS;
			endcase
		end
		if (st.level != st.pressed) begin
			next_st.dbnc_ms = '0;
		end else if (ms_tick) begin
			if (st.dbnc_ms >= dbnc_lim) begin
				next_st.pressed = !st.pressed;
				next_st.press_p = !st.pressed;
				next_st.release_p = st.pressed;
				next_st.dbnc_ms = '0;
			end else begin
				next_st.dbnc_ms = st.dbnc_ms + 1'b1;
			end
		end
		if (!st.pressed || !next_st.pressed) begin
			next_st.hold_ms = '0;
		end else if (ms_tick && (st.hold_ms != '1)) begin
			next_st.hold_ms = st.hold_ms + 1'b1;
			next_st.hold_tick = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bif.pin_level = st.level;
	assign bif.pressed = st.pressed;
	assign bif.press_p = st.press_p;
	assign bif.release_p = st.release_p;
	assign bif.hold_tick = st.hold_tick;
	assign bif.hold_ms = st.hold_ms;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_HOLD_CLEARS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$fell(st.pressed) |-> (st.hold_ms == '0) ##1 (st.hold_ms == '0))
		else $error("hold timer not cleared on release");
	AST_DBNC_SHORT_RISE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$fell(st.pressed) |-> $past(st.dbnc_ms) == pbsi_pkg::DBNC_SHORT_MS)
		else $error("release debounce not short");
endmodule
`default_nettype wire

// File: hdl/pbsi_top.sv
/*
 power button and standby input block: mode, sense, latches, hold events,
 long press reset or turn off, standby polarity.
 assumes pins are asynchronous and the sequencer answers power-down requests.
*/
`timescale 1ns/1ps
`default_nettype none
module pbsi_top #(
	parameter int MS_CYCLES = pbsi_pkg::MS_TICK_CYCLES,
	parameter int DISCHARGE_CYCLES = pbsi_pkg::DISCHARGE_CYCLES
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// pins
	input wire logic power_on_button_input_i,
	input wire logic standby_pin_i,
	// nvm configuration
	input wire logic nvm_button_mode_select_i,
	input wire logic [1:0] nvm_button_debounce_default_i,
	input wire logic [1:0] nvm_long_press_delay_default_i,
	// software control
	input wire logic button_debounce_select_wr_i,
	input wire logic [1:0] button_debounce_select_wdata_i,
	input wire logic long_press_delay_select_wr_i,
	input wire logic [1:0] long_press_delay_select_wdata_i,
	input wire logic long_press_reset_enable_i,
	input wire logic low_power_pin_polarity_i,
	input wire logic [pbsi_pkg::LATCH_N-1:0] latch_clear_i,
	// system state
	input wire logic system_on_i,
	input wire logic power_down_done_i,
	// status
	output logic button_level_sense_o,
	output logic [1:0] button_debounce_select_o,
	output logic [1:0] long_press_delay_select_o,
	output logic [pbsi_pkg::LATCH_N-1:0] button_latches_o,
	// events
	output logic off_mode_o,
	output logic power_on_event_o,
	output logic turn_off_event_o,
	output logic power_down_request_o,
	output logic power_up_request_o,
	output logic standby_o
);
	typedef enum logic [1:0] {RS_IDLE, RS_PDOWN, RS_DISCH, RS_PUP} pbsi_rst_state_t;

	typedef struct packed {
		logic init_done;
		logic [1:0] dbnc_sel;
		logic [1:0] delay_sel;
		logic [pbsi_pkg::LATCH_N-1:0] latch;
		logic [2:0] sb_sync;
		logic sb_level;
		logic standby;
		logic long_done;
		pbsi_rst_state_t rs;
		logic [pbsi_pkg::DISCH_W-1:0] disch_cnt;
		logic pon_evt;
		logic off_evt;
		logic pup;
		logic off_mode;
	} pbsi_top_state_t;

	pbsi_top_state_t st;
	pbsi_top_state_t next_st;
	logic edge_mode;
	logic [pbsi_pkg::LATCH_N-1:0] latch_set;
	logic long_hit;
	logic [pbsi_pkg::HOLD_W-1:0] long_ms;

	pbsi_btn_if bif ();

	// ------------------------------------------------------------
	// pin filter
	// ------------------------------------------------------------
	pbsi_btn_filter #(
		.MS_CYCLES(MS_CYCLES)
	) u_filter (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(power_on_button_input_i),
		.bif(bif)
	);

	assign bif.dbnc_sel = st.dbnc_sel;

	// ------------------------------------------------------------
	// control
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.pon_evt = 1'b0;
		next_st.off_evt = 1'b0;
		next_st.pup = 1'b0;
		latch_set = '0;
		edge_mode = nvm_button_mode_select_i;
		long_ms = pbsi_pkg::LONG_PRESS_MS[st.delay_sel];
		long_hit = 1'b0;

		// configuration load and writes
		if (!st.init_done) begin
			next_st.init_done = 1'b1;
			next_st.dbnc_sel = nvm_button_debounce_default_i;
			next_st.delay_sel = nvm_long_press_delay_default_i;
		end else begin
			if (button_debounce_select_wr_i) begin
				next_st.dbnc_sel = button_debounce_select_wdata_i;
			end
			if (long_press_delay_select_wr_i) begin
				next_st.delay_sel = long_press_delay_select_wdata_i;
			end
		end

		// standby pin
		next_st.sb_sync = {st.sb_sync[1:0], standby_pin_i};
		if (st.sb_sync[2] == st.sb_sync[1]) begin
			next_st.sb_level = st.sb_sync[2];
		end
		next_st.standby = st.sb_level ^ low_power_pin_polarity_i;

		// level mode off state
		next_st.off_mode = !edge_mode && bif.pressed;

		// power on events
		if (!system_on_i && (st.rs == RS_IDLE)) begin
			if (edge_mode && bif.press_p) begin
				next_st.pon_evt = 1'b1;
			end
			if (!edge_mode && bif.release_p) begin
				next_st.pon_evt = 1'b1;
			end
		end

		// latch events
		if (edge_mode && bif.press_p) begin
			latch_set[pbsi_pkg::LAT_PRESS] = 1'b1;
		end
		if (edge_mode && system_on_i && bif.release_p) begin
			latch_set[pbsi_pkg::LAT_RELEASE] = 1'b1;
		end
		for (int i = 0; i < pbsi_pkg::HOLD_N; i++) begin
			if (edge_mode && bif.hold_tick && (bif.hold_ms == pbsi_pkg::HOLD_MS[i])) begin
				latch_set[pbsi_pkg::LAT_HOLD0 + i] = 1'b1;
			end
		end
		next_st.latch = (st.latch & ~latch_clear_i) | latch_set;

		// long press
		if (!bif.pressed) begin
			next_st.long_done = 1'b0;
		end else if (edge_mode && system_on_i && bif.hold_tick && (bif.hold_ms == long_ms) && !st.long_done) begin
			long_hit = 1'b1;
			next_st.long_done = 1'b1;
			if (long_press_reset_enable_i) begin
				if (st.rs == RS_IDLE) begin
					next_st.rs = RS_PDOWN;
				end
			end else begin
				next_st.off_evt = 1'b1;
			end
		end

		// controller reset sequence
		case (st.rs)
			RS_IDLE: begin
			end
			RS_PDOWN: begin
				if (power_down_done_i) begin
					next_st.rs = RS_DISCH;
					next_st.disch_cnt = '0;
				end
			end
			RS_DISCH: begin
				if (st.disch_cnt == pbsi_pkg::DISCH_W'(DISCHARGE_CYCLES - 1)) begin
					next_st.rs = RS_PUP;
				end else begin
					next_st.disch_cnt = st.disch_cnt + 1'b1;
				end
			end
			RS_PUP: begin
				next_st.pup = 1'b1;
				next_st.dbnc_sel = nvm_button_debounce_default_i;
				next_st.delay_sel = nvm_long_press_delay_default_i;
				next_st.rs = RS_IDLE;
			end
			default: begin
				next_st.rs = RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign button_level_sense_o = !bif.pin_level;
	assign button_debounce_select_o = st.dbnc_sel;
	assign long_press_delay_select_o = st.delay_sel;
	assign button_latches_o = st.latch;
	assign off_mode_o = st.off_mode;
	assign power_on_event_o = st.pon_evt;
	assign turn_off_event_o = st.off_evt;
	assign power_down_request_o = (st.rs == RS_PDOWN);
	assign power_up_request_o = st.pup;
	assign standby_o = st.standby;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_SENSE_INVERTED: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		button_level_sense_o != bif.pin_level)
		else $error("sense bit not inverted");
	AST_LEVEL_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(!nvm_button_mode_select_i && bif.pressed && $past(bif.pressed)) |-> (off_mode_o && !power_on_event_o))
		else $error("level mode low pin not off");
	AST_STANDBY_POLARITY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(st.sb_level != low_power_pin_polarity_i) |=> standby_o)
		else $error("standby polarity wrong");
	AST_PRESS_SETS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(nvm_button_mode_select_i && system_on_i && bif.press_p) |=> button_latches_o[pbsi_pkg::LAT_PRESS])
		else $error("press latch not set");
	AST_RELEASE_SETS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(nvm_button_mode_select_i && system_on_i && bif.release_p) |=> button_latches_o[pbsi_pkg::LAT_RELEASE])
		else $error("release latch not set");
	AST_HOLD_ONE_SEC: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(nvm_button_mode_select_i && bif.hold_tick && bif.hold_ms == pbsi_pkg::HOLD_MS[0])
		|=> button_latches_o[pbsi_pkg::LAT_HOLD0])
		else $error("one second latch not set");
	AST_SET_WINS_CLEAR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(latch_clear_i[pbsi_pkg::LAT_PRESS] && latch_set[pbsi_pkg::LAT_PRESS])
		|=> button_latches_o[pbsi_pkg::LAT_PRESS])
		else $error("latch clear beat a set");
	AST_LONG_RESET: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(long_hit && long_press_reset_enable_i && st.rs == RS_IDLE) |=> power_down_request_o && !turn_off_event_o)
		else $error("long press reset not started");
	AST_LONG_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(long_hit && !long_press_reset_enable_i) |=> turn_off_event_o && !power_down_request_o)
		else $error("long press turn off missing");
	AST_DELAY_DECODE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(st.delay_sel == 2'h3) |-> (long_ms == 14'h3e80))
		else $error("long press delay decode wrong");
	AST_POWER_UP_RELOAD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		power_up_request_o |-> (button_debounce_select_o == $past(nvm_button_debounce_default_i)
		&& long_press_delay_select_o == $past(nvm_long_press_delay_default_i) && $past(st.rs) == RS_PUP))
		else $error("power up without nvm reload");
	AST_INIT_LOAD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$rose(st.init_done) |-> button_debounce_select_o == $past(nvm_button_debounce_default_i))
		else $error("debounce default not loaded");
	AST_EIGHT_SEC_SETS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(nvm_button_mode_select_i && bif.hold_tick && bif.hold_ms == pbsi_pkg::HOLD_MS[4])
		|=> button_latches_o[pbsi_pkg::LAT_HOLD0 + 4])
		else $error("eight second latch not set");
	AST_EDGE_POWER_ON: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(nvm_button_mode_select_i && !system_on_i && st.rs == RS_IDLE && bif.press_p) |=> power_on_event_o)
		else $error("edge mode power on missing");
	AST_LEVEL_POWER_ON: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(!nvm_button_mode_select_i && !system_on_i && st.rs == RS_IDLE && bif.release_p) |=> power_on_event_o)
		else $error("level mode power on missing");
	AST_LEVEL_NO_LATCH: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(!nvm_button_mode_select_i && button_latches_o == '0) |=> (button_latches_o == '0))
		else $error("latch set in level mode");
	AST_EDGE_NO_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(nvm_button_mode_select_i && $past(nvm_button_mode_select_i)) |-> !off_mode_o)
		else $error("off mode in edge mode");
	AST_PDOWN_HOLDS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(power_down_request_o && !power_down_done_i) |=> power_down_request_o)
		else $error("power down request dropped early");
	AST_DISCHARGE_END: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(st.rs == RS_DISCH && st.disch_cnt == pbsi_pkg::DISCH_W'(DISCHARGE_CYCLES - 1)) |=> ##1 power_up_request_o)
		else $error("power up not after discharge");
	AST_STANDBY_LEAVE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(st.sb_level == low_power_pin_polarity_i) |=> !standby_o)
		else $error("standby not left");
	AST_DBNC_WRITE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(st.init_done && st.rs != RS_PUP && button_debounce_select_wr_i)
		|=> (button_debounce_select_o == $past(button_debounce_select_wdata_i)))
		else $error("debounce select write lost");
endmodule
`default_nettype wire

// File: verif/pbsi_button_model.sv
/*
 partner model: push button with supply pull-up, and host driving standby.
 assumes requests change at the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pbsi_button_model (
	// clock
	input wire logic core_clk_i,
	// requests
	input wire logic press_i,
	input wire logic bounce_i,
	input wire logic standby_req_i,
	input wire logic polarity_i,
	// pins
	output logic button_o,
	output logic standby_pin_o
);
	logic [4:0] chatter = 5'h00;
	logic last_press = 1'b0;
	// ----------------------------------------
	// contact chatter after each change
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		last_press <= press_i;
		if (bounce_i && press_i != last_press)
			chatter <= 5'h10;
		else if (chatter != 5'h00)
			chatter <= chatter - 5'h01;
	end
	// pressed shorts to ground, released is pulled up
	assign button_o = (chatter != 5'h00) ? chatter[0] : ~press_i;
	// host sets the pin so standby follows its request
	assign standby_pin_o = standby_req_i ^ polarity_i;
endmodule
`default_nettype wire

// File: verif/pbsi_top_bench.sv
/*
 self-checking bench of the power button and standby block.
 assumes shortened ms tick and discharge counts.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("[ERR] %s expected %0h seen %0h", nm, e, a); end end
module pbsi_top_bench;
	localparam int MS = 4;
	localparam int DIS = 8;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic press = 1'b0, bounce = 1'b0, stby_req = 1'b0, pol = 1'b0, mode = 1'b1;
	logic dbnc_wr = 1'b0, delay_wr = 1'b0, rst_en = 1'b0, sys_on = 1'b1, pd_done = 1'b0;
	logic [1:0] dbnc_wd = 2'h0, delay_wd = 2'h0;
	logic [6:0] clr = 7'h00;
	logic pin, stby_pin, sense, off_mode, pwr_on, turn_off, pd_req, pu_req, stby;
	logic [1:0] dbnc_sel, delay_sel;
	logic [6:0] lat;
	int fails = 0, checked = 0, cyc = 0, n_on = 0, n_off = 0, t_off = 0, n, t;
	int fall[4] = '{32, 32, 125, 750};
	int hold[5] = '{1000, 2000, 3000, 4000, 8000};

	always #2.5 core_clk_i = ~core_clk_i;

	pbsi_button_model model (.core_clk_i(core_clk_i), .press_i(press), .bounce_i(bounce),
		.standby_req_i(stby_req), .polarity_i(pol), .button_o(pin), .standby_pin_o(stby_pin));

	pbsi_top #(.MS_CYCLES(MS), .DISCHARGE_CYCLES(DIS)) dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.power_on_button_input_i(pin), .standby_pin_i(stby_pin), .nvm_button_mode_select_i(mode),
		.nvm_button_debounce_default_i(2'h2), .nvm_long_press_delay_default_i(2'h1),
		.button_debounce_select_wr_i(dbnc_wr), .button_debounce_select_wdata_i(dbnc_wd),
		.long_press_delay_select_wr_i(delay_wr), .long_press_delay_select_wdata_i(delay_wd),
		.long_press_reset_enable_i(rst_en), .low_power_pin_polarity_i(pol), .latch_clear_i(clr),
		.system_on_i(sys_on), .power_down_done_i(pd_done), .button_level_sense_o(sense),
		.button_debounce_select_o(dbnc_sel), .long_press_delay_select_o(delay_sel),
		.button_latches_o(lat), .off_mode_o(off_mode), .power_on_event_o(pwr_on),
		.turn_off_event_o(turn_off), .power_down_request_o(pd_req), .power_up_request_o(pu_req),
		.standby_o(stby));

	// ----------------------------------------
	// event counters and timeout
	// ----------------------------------------
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (pwr_on === 1'b1)
			n_on <= n_on + 1;
		if (turn_off === 1'b1) begin
			n_off <= n_off + 1;
			t_off <= cyc;
		end
		if (cyc == 90000) begin
			fails++;
			final_report();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask

	task automatic set_press(input logic v);
		@(posedge core_clk_i);
		press <= v;
	endtask

	task automatic wait_lat(input int b, input int lim, output int k);
		k = 0;
		while (lat[b] !== 1'b1 && k < lim) begin
			tick(1);
			k++;
		end
	endtask

	task automatic clear_all();
		@(posedge core_clk_i);
		clr <= 7'h7f;
		@(posedge core_clk_i);
		clr <= 7'h00;
		tick(1);
		`CHK("latches", 7'h00, lat)
	endtask

	task automatic wr_sel(input logic dly, input logic [1:0] v);
		@(posedge core_clk_i);
		if (dly) begin
			delay_wr <= 1'b1;
			delay_wd <= v;
		end else begin
			dbnc_wr <= 1'b1;
			dbnc_wd <= v;
		end
		@(posedge core_clk_i);
		dbnc_wr <= 1'b0;
		delay_wr <= 1'b0;
		tick(1);
	endtask

	task automatic final_report();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		tick(2);
		`CHK("sense in reset", 1'b1, sense)
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		tick(8);
		`CHK("debounce default", 2'h2, dbnc_sel)
		`CHK("delay default", 2'h1, delay_sel)
		`CHK("sense released", 1'b0, sense)
		for (int c = 0; c < 4; c++) begin
			wr_sel(1'b0, c[1:0]);
			`CHK("debounce select", c[1:0], dbnc_sel)
			@(posedge core_clk_i);
			bounce <= (c == 3);
			press <= 1'b1;
			wait_lat(0, 4000, n);
			`CHK("sense pressed", 1'b1, sense)
			`CHK("press time", 1'b1, n >= fall[c] * MS && n <= fall[c] * MS + 2 * MS + 24)
			set_press(1'b0);
			wait_lat(1, 400, n);
			`CHK("release time", 1'b1, n >= 32 * MS && n <= 34 * MS + 32)
			clear_all();
		end
		@(posedge core_clk_i);
		bounce <= 1'b0;
		wr_sel(1'b1, 2'h3);
		`CHK("delay select top code", 2'h3, delay_sel)
		wr_sel(1'b1, 2'h0);
		`CHK("delay select", 2'h0, delay_sel)
		wr_sel(1'b0, 2'h0);
		set_press(1'b1);
		wait_lat(0, 400, n);
		t = 0;
		n = cyc;
		for (int k = 0; k < 5; k++) begin
			wait_lat(2 + k, 40000, n);
			t += n;
			`CHK("hold time", 1'b1, t >= hold[k] * MS - MS - 4 && t <= hold[k] * MS + MS + 4)
		end
		`CHK("turn off count", 1, n_off)
		`CHK("turn off time", 1'b1, t_off - (cyc - t) >= 2000 * MS - MS - 4 && t_off - (cyc - t) <= 2000 * MS + MS + 4)
		set_press(1'b0);
		wait_lat(1, 400, n);
		`CHK("sticky latches", 7'h7f, lat)
		clear_all();
		for (int k = 0; k < 2; k++) begin
			set_press(1'b1);
			tick(600 * MS);
			set_press(1'b0);
			tick(100 * MS);
		end
		`CHK("hold timer restart", 1'b0, lat[2])
		@(posedge core_clk_i);
		rst_en <= 1'b1;
		set_press(1'b1);
		n = 0;
		while (pd_req !== 1'b1 && n < 9000) begin
			tick(1);
			n++;
		end
		`CHK("reset delay", 1'b1, n >= 2031 * MS && n <= 2034 * MS + 24)
		set_press(1'b0);
		tick(5);
		`CHK("power down held", 1'b1, pd_req)
		@(posedge core_clk_i);
		pd_done <= 1'b1;
		n = 0;
		while (pu_req !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		`CHK("discharge wait", 1'b1, n >= DIS && n <= DIS + 4)
		`CHK("reload debounce", 2'h2, dbnc_sel)
		`CHK("reload delay", 2'h1, delay_sel)
		`CHK("no turn off", 1, n_off)
		@(posedge core_clk_i);
		pd_done <= 1'b0;
		sys_on <= 1'b0;
		rst_en <= 1'b0;
		tick(40 * MS);
		clear_all();
		@(posedge core_clk_i);
		clr <= 7'h01;
		press <= 1'b1;
		wait_lat(0, 600, n);
		`CHK("press latch off state", 1'b1, lat[0])
		`CHK("power on time", 1'b1, n >= 125 * MS && n <= 127 * MS + 24)
		tick(1);
		`CHK("clear with set", 1'b0, lat[0])
		@(posedge core_clk_i);
		clr <= 7'h00;
		tick(4);
		`CHK("power on", 1, n_on)
		set_press(1'b0);
		tick(40 * MS);
		`CHK("no release latch off state", 1'b0, lat[1])
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk_i);
			pol <= k[1];
			stby_req <= k[0];
			tick(6);
			`CHK("standby", k[0], stby)
		end
		@(posedge core_clk_i);
		arst_n_i <= 1'b0;
		mode <= 1'b0;
		press <= 1'b1;
		tick(2);
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		tick(130 * MS);
		`CHK("level off mode", 1'b1, off_mode)
		`CHK("no power on while low", 1, n_on)
		set_press(1'b0);
		tick(40 * MS);
		`CHK("level off mode left", 1'b0, off_mode)
		`CHK("level power on", 2, n_on)
		`CHK("no latch in level mode", 7'h00, lat)
		final_report();
	end
endmodule
`default_nettype wire
